// ### ring_signal_validation.sv
/*
 * Ring qualification: times line polarity events, checks the ring
 * frequency window, confirms, delays and reports a valid ring, and
 * ends it after a quiet timeout. Registers sit on a Wishbone slave.
 * Assumes line_polarity_i is asynchronous and a classic single-cycle
 * Wishbone master that holds each request until ack.
 */
`timescale 1ns/100ps
module ring_signal_validation
    import ring_validation_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [31:0]      wb_dat_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic             wb_we_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    output logic [31:0]           wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic             line_polarity_i,
    output logic                  ring_valid_o,
    output logic                  irq_o
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [2:0]       sync;
        logic             pol;
        logic             ack;
        logic [31:0]      dat;
        logic [7:0]       dly_max;
        logic [7:0]       timing;
        logic [7:0]       enable;
        logic [EV_W-1:0]  events;
        logic [EV_W-1:0]  mask;
        logic             irq;
        qual_state_t      fsm;
        logic             armed;
        logic [SIX_MSB:0] tmr;
        logic [CNT_W-1:0] conf;
        logic [CNT_W-1:0] dly;
        logic [CNT_W-1:0] end_cnt;
        logic             valid;
    } ring_regs_t;

    ring_regs_t       r_q;
    ring_regs_t       r_d;

    logic             tick;
    logic             ev;
    logic             bad;
    logic             en;
    logic             hit;
    logic             tmo_hit;
    logic             ev_rd;
    logic [EV_W-1:0]  set_ev;
    logic [SIX_MSB:0] ras;
    logic [SIX_MSB:0] max_thr;
    logic [CNT_W-1:0] conf_lim;
    logic [CNT_W-1:0] dly_lim;
    logic [CNT_W-1:0] tmo_lim;

    // ****************************************
    // Tick source
    // ****************************************
    // One shared divider keeps every millisecond figure on the same tick grid
    ring_tick_div #(
        .TICK_LEN (TICK_LEN)
    ) u_tick (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .tick_o    (tick)
    );

    // ****************************************
    // Field decode
    // ****************************************
    assign en       = r_q.enable[ENA_BIT]; // RULE5
    assign ras      = r_q.enable[SIX_MSB:0];
    assign max_thr  = r_q.dly_max[SIX_MSB:0];
    assign conf_lim = confirm_ticks(r_q.timing[CONF_MSB:0]); // RULE4
    // Report delay code is split across two registers
    assign dly_lim  = delay_ticks({r_q.timing[DLY_HI_BIT],
                                   r_q.dly_max[DLY_LO_MSB:DLY_LO_LSB]}); // RULE1
    assign tmo_lim  = timeout_ticks(r_q.timing[TMO_MSB:TMO_LSB]); // RULE2

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        r_d     = r_q;
        ev      = 1'b0;
        bad     = 1'b0;
        tmo_hit = 1'b0;
        set_ev  = '0;
        hit     = wb_cyc_i && wb_stb_i && !r_q.ack;
        ev_rd   = hit && !wb_we_i && (wb_adr_i == OFS_EVENT);

        // Pin filter: a level counts once the second and third stages agree
        r_d.sync = {r_q.sync[1:0], line_polarity_i};
        if (r_q.sync[2] == r_q.sync[1] && r_q.sync[2] != r_q.pol) begin
            r_d.pol = r_q.sync[2];
            ev      = 1'b1;
        end

        // Bus slave: one-cycle ack, unmapped reads return zero
        r_d.ack = hit;
        r_d.dat = '0;
        if (hit && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                OFS_DELAY_MAX: r_d.dly_max = wb_dat_i[7:0];
                OFS_TIMING:    r_d.timing  = wb_dat_i[7:0];
                OFS_ENABLE:    r_d.enable  = wb_dat_i[7:0] & ENA_WMASK; // RULE6
                OFS_MASK:      r_d.mask    = wb_dat_i[EV_W-1:0];
                default:       r_d.dat     = '0;
            endcase
        end
        if (hit && !wb_we_i) begin
            case (wb_adr_i)
                OFS_DELAY_MAX: r_d.dat = {24'h000000, r_q.dly_max};
                OFS_TIMING:    r_d.dat = {24'h000000, r_q.timing};
                OFS_ENABLE:    r_d.dat = {24'h000000, r_q.enable};
                OFS_EVENT:     r_d.dat = {29'h0000000, r_q.events};
                OFS_MASK:      r_d.dat = {29'h0000000, r_q.mask};
                OFS_STATE:     r_d.dat = {28'h0000000, r_q.armed, r_q.fsm, r_q.valid};
                default:       r_d.dat = '0;
            endcase
        end

        // Qualification
        if (!en) begin
            // Disabled: hold everything idle, no indication
            r_d.fsm     = Q_IDLE; // RULE5
            r_d.armed   = 1'b0;
            r_d.tmr     = '0;
            r_d.conf    = '0;
            r_d.dly     = '0;
            r_d.end_cnt = '0;
            r_d.valid   = 1'b0;
        end else begin
            // Countdown: reload on every event, decrement per tick
            if (ev) begin
                r_d.tmr = ras; // RULE7
            end else if (tick && r_q.tmr != '0) begin
                r_d.tmr = r_q.tmr - 6'h01; // RULE7
            end

            // Quiet time since the latest crossing
            if (ev) begin
                r_d.end_cnt = '0; // RULE2
            end else if (tick && r_q.fsm != Q_IDLE) begin
                r_d.end_cnt = r_q.end_cnt + 10'h001;
            end

            // Spacing check on every event after the first one;
            // window opens ras minus rmx ticks after the previous event and closes at ras ticks
            bad = ev && r_q.armed
                  && (r_q.tmr == '0 // RULE8
                      || r_q.tmr > max_thr); // RULE11 RULE9
            if (ev) begin
                r_d.armed = 1'b1;
            end

            case (r_q.fsm)
                Q_IDLE: begin
                    if (ev) begin
                        r_d.fsm  = Q_CONFIRM;
                        r_d.conf = '0;
                    end
                end
                // Confirm pauses while the countdown is empty; the next event then invalidates
                Q_CONFIRM: begin
                    if (bad) begin
                        r_d.conf          = '0; // RULE12
                        set_ev[EV_INVALID] = 1'b1;
                    end else if (tick && r_q.tmr != '0) begin
                        r_d.conf = r_q.conf + 10'h001;
                        if (r_q.conf + 10'h001 >= conf_lim) begin
                            r_d.fsm = Q_DELAY; // RULE4
                            r_d.dly = '0;
                        end
                    end
                end
                Q_DELAY: begin
                    if (bad) begin
                        // Frequency drifted out before report: start over
                        r_d.fsm           = Q_CONFIRM; // RULE12
                        r_d.conf          = '0;
                        set_ev[EV_INVALID] = 1'b1;
                    end else if (r_q.dly >= dly_lim) begin
                        r_d.fsm          = Q_VALID; // RULE1 RULE13
                        r_d.valid        = 1'b1;
                        set_ev[EV_VALID] = 1'b1;
                    end else if (tick) begin
                        r_d.dly = r_q.dly + 10'h001;
                    end
                end
                Q_VALID: begin
                    r_d.valid = 1'b1;
                end
                default: begin
                    r_d.fsm = Q_IDLE;
                end
            endcase

            // Timeout overrides every state update except in a cycle with an event; code zero ends at once
            tmo_hit = r_q.fsm != Q_IDLE && !ev && r_q.end_cnt >= tmo_lim; // RULE3
            if (tmo_hit) begin
                r_d.fsm     = Q_IDLE; // RULE2 RULE13
                r_d.armed   = 1'b0;
                r_d.valid   = 1'b0;
                r_d.conf    = '0;
                r_d.dly     = '0;
                r_d.end_cnt = '0;
                if (r_q.valid) begin
                    set_ev[EV_END] = 1'b1;
                end
            end
        end

        // Sticky events: read clears, a new event in that cycle survives
        if (ev_rd) begin
            r_d.events = set_ev;
        end else begin
            r_d.events = r_q.events | set_ev;
        end
        r_d.irq = |(r_d.events & r_d.mask);
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q         <= '0;
            r_q.dly_max <= RST_DELAY_MAX;
            r_q.timing  <= RST_TIMING;
            r_q.enable  <= RST_ENABLE;
            r_q.mask    <= RST_MASK;
            r_q.fsm     <= Q_IDLE;
        end else begin
            r_q <= r_d;
        end
    end

    assign wb_dat_o     = r_q.dat;
    assign wb_ack_o     = r_q.ack;
    assign ring_valid_o = r_q.valid;
    assign irq_o        = r_q.irq;

    // ****************************************
    // Checks
    // ****************************************
    AST_TMR_LOAD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
        (ev && en) |=> (r_q.tmr == $past(ras)))
        else $error("countdown not loaded on polarity event");

    AST_TMR_DEC: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE7
        (tick && !ev && en && r_q.tmr != '0) |=> (r_q.tmr == $past(r_q.tmr) - 6'h01))
        else $error("countdown did not step on tick");

    AST_TOO_LOW: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE8
        (ev && en && r_q.armed && r_q.tmr == '0 && r_q.fsm == Q_CONFIRM)
        |=> (r_q.conf == '0 && r_q.events[EV_INVALID]))
        else $error("late event did not invalidate");

    AST_TOO_HIGH: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE11
        (ev && en && r_q.armed && r_q.tmr > max_thr && (r_q.fsm == Q_CONFIRM || r_q.fsm == Q_DELAY))
        |=> (r_q.fsm == Q_CONFIRM && r_q.conf == '0 && r_q.events[EV_INVALID]))
        else $error("early event did not invalidate");

    AST_OFF: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE5
        !en |=> (!ring_valid_o && r_q.fsm == Q_IDLE))
        else $error("activity while validation disabled");

    AST_CONFIRM: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
        (r_q.fsm == Q_DELAY && $past(r_q.fsm) == Q_CONFIRM)
        |-> ($past(r_q.conf) + 10'h001 >= $past(conf_lim)))
        else $error("confirmation ended early");

    AST_REPORT: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
        $rose(ring_valid_o) |-> ($past(r_q.fsm) == Q_DELAY && $past(r_q.dly) >= $past(dly_lim)))
        else $error("valid ring reported before delay");

    AST_TIMEOUT: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
        (ring_valid_o && en && !ev && r_q.end_cnt >= tmo_lim)
        |=> (!ring_valid_o && r_q.events[EV_END]))
        else $error("ring not ended on timeout");

    AST_RSV_READ: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE6
        (hit && !wb_we_i && wb_adr_i == OFS_ENABLE) |=> !wb_dat_o[RSV_BIT])
        else $error("reserved enable bit reads one");

    AST_ACK_PULSE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held beyond one cycle");

    // Bus slave answers in the next cycle and keeps its data lines quiet otherwise
    AST_ACK_NEXT: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        hit |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");

    AST_DAT_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !wb_ack_o |-> (wb_dat_o == 32'h00000000))
        else $error("read data driven outside ack");

    AST_WR_LAND: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE4
        (hit && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_TIMING) |=> (r_q.timing == $past(wb_dat_i[7:0])))
        else $error("timing write did not land");

    AST_IRQ_LEVEL: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        irq_o == (|(r_q.events & r_q.mask)))
        else $error("interrupt level does not follow unmasked events");

    AST_STICKY: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        !ev_rd |=> ((r_q.events & $past(r_q.events)) == $past(r_q.events)))
        else $error("event bit lost without a read");

    AST_END_RESTART: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
        (ev && en) |=> (r_q.end_cnt == 10'h000))
        else $error("quiet timer not restarted by polarity event");

    AST_TMO_IDLE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE2
        (en && tmo_hit) |=> (r_q.fsm == Q_IDLE && !r_q.armed))
        else $error("timeout did not return to idle");

    AST_VALID_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE13
        (ring_valid_o && en && !tmo_hit) |=> ring_valid_o)
        else $error("valid ring dropped before timeout");

    AST_DELAY_DONE: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE1
        (r_q.fsm == Q_DELAY && en && !bad && !tmo_hit && r_q.dly >= dly_lim) |=> ring_valid_o)
        else $error("valid ring not reported after delay");

    AST_OFF_QUIET: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE5
        !en |=> ((r_q.events | $past(r_q.events)) == $past(r_q.events)))
        else $error("event raised while validation disabled");

endmodule : ring_signal_validation

// ### ring_validation_pkg.sv
/*
 * Constants, field layouts, state types and time conversion helpers
 * for the ring qualification block.
 * Assumes a single 250 MHz system clock and a 32-bit Wishbone slave port.
 */
// Functional notes
// RULE1: Report delay after validation, 3-bit code.
// RULE2: Ring over after timeout since last crossing.
// RULE3: Software never writes timeout code zero.
// RULE4: Valid only after in-range confirmation time.
// RULE5: Enable bit off stops all validation.
// RULE6: Software writes reserved enable bit as zero.
// RULE7: Polarity event loads countdown with assertion time.
// RULE8: Event after countdown expiry means too low.
// RULE9: Assertion minus threshold gives minimum spacing.
// RULE10: Software sizes assertion time from minimum frequency.
// RULE11: Remaining count above threshold means too high.
// RULE12: Ticks from divider; invalidation restarts confirmation.
// RULE13: Valid after confirm plus delay; ends on timeout.
package ring_validation_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned TICK_NS       = 2_000_000;
    localparam int unsigned TICK_MS       = 2;
    localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W         = 20;
    localparam int unsigned CNT_W         = 10;

    localparam int unsigned CONFIRM_MS [8] = '{100, 150, 200, 256, 384, 512, 640, 1024};
    localparam int unsigned DELAY_MS   [4] = '{0, 256, 512, 1792};
    localparam int unsigned TMO_STEP_MS    = 128;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int unsigned ADR_W         = 8;
    localparam logic [7:0]  OFS_DELAY_MAX = 8'h10;
    localparam logic [7:0]  OFS_TIMING    = 8'h14;
    localparam logic [7:0]  OFS_ENABLE    = 8'h18;
    localparam logic [7:0]  OFS_EVENT     = 8'h1C;
    localparam logic [7:0]  OFS_MASK      = 8'h20;
    localparam logic [7:0]  OFS_STATE     = 8'h24;

    localparam logic [7:0]  RST_DELAY_MAX = 8'h00;
    localparam logic [7:0]  RST_TIMING    = 8'h08;
    localparam logic [7:0]  RST_ENABLE    = 8'h19;
    localparam logic [2:0]  RST_MASK      = 3'h0;

    // ****************************************
    // Fields
    // ****************************************
    localparam int unsigned DLY_HI_BIT  = 7;
    localparam int unsigned TMO_MSB     = 6;
    localparam int unsigned TMO_LSB     = 3;
    localparam int unsigned CONF_MSB    = 2;
    localparam int unsigned DLY_LO_MSB  = 7;
    localparam int unsigned DLY_LO_LSB  = 6;
    localparam int unsigned SIX_MSB     = 5;
    localparam int unsigned ENA_BIT     = 7;
    localparam int unsigned RSV_BIT     = 6;
    localparam logic [7:0]  ENA_WMASK   = 8'hBF;

    localparam int unsigned EV_VALID    = 0;
    localparam int unsigned EV_END      = 1;
    localparam int unsigned EV_INVALID  = 2;
    localparam int unsigned EV_W        = 3;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        Q_IDLE    = 2'b00,
        Q_CONFIRM = 2'b01,
        Q_DELAY   = 2'b10,
        Q_VALID   = 2'b11
    } qual_state_t;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } div_regs_t;

    // ****************************************
    // Code to tick-count conversion
    // ****************************************
    function automatic logic [CNT_W-1:0] confirm_ticks(input logic [2:0] code);
        return CNT_W'(CONFIRM_MS[code] / TICK_MS);
    endfunction : confirm_ticks

    // Undefined codes fall back on their two low bits
    function automatic logic [CNT_W-1:0] delay_ticks(input logic [2:0] code);
        return CNT_W'(DELAY_MS[code[1:0]] / TICK_MS);
    endfunction : delay_ticks

    function automatic logic [CNT_W-1:0] timeout_ticks(input logic [3:0] code);
        return CNT_W'((32'(code) * TMO_STEP_MS) / TICK_MS);
    endfunction : timeout_ticks

endpackage : ring_validation_pkg

// ### ring_tick_div.sv
/*
 * Divider that turns the system clock into the nominal 2 ms tick.
 * Assumes TICK_LEN of at least 2 so that ticks never merge.
 */
`timescale 1ns/100ps
module ring_tick_div
    import ring_validation_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);

    localparam logic [DIV_W-1:0] LAST = DIV_W'(TICK_LEN - 1);

    div_regs_t r_q;
    div_regs_t r_d;

    always_comb begin
        r_d      = r_q;
        r_d.tick = 1'b0;
        if (r_q.cnt == LAST) begin
            r_d.cnt  = '0;
            r_d.tick = 1'b1; // RULE12
        end else begin
            r_d.cnt = r_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign tick_o = r_q.tick;

    AST_TICK_GAP: assert property (@(posedge sys_clk_i) disable iff (rst_i) // RULE12
        tick_o |=> !tick_o)
        else $error("tick pulses back to back");

endmodule : ring_tick_div

// ### ring_line_model.sv
/*
 * Line side model: toggles the line polarity every gap_i clocks while run_i is high.
 * Assumes the bench picks a gap that suits the programmed assertion time.
 */
`timescale 1ns/100ps
module ring_line_model (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic [15:0] gap_i,
    output logic             line_polarity_o
);
    // ****************************************
    // Polarity generator
    // ****************************************
    logic [15:0] cnt_q;

    // Polarity holds its level between rings, as a real line does
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q           <= 16'h0000;
            line_polarity_o <= 1'b0;
        end else if (!run_i) begin
            cnt_q <= 16'h0000;
        end else if (cnt_q == 16'h0000) begin
            line_polarity_o <= ~line_polarity_o;
            cnt_q           <= gap_i - 16'h0001;
        end else begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end
endmodule : ring_line_model

// ### tb.sv
/*
 * Bench for the ring qualification block: Wishbone tasks, line model, timed checks.
 * Assumes TICK_LEN of 10 clocks, so one tick is 10 cycles of the 4 ns clock.
 */
`timescale 1ns/100ps
module tb;
    import ring_validation_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    localparam int TL = 10;
    logic        sys_clk_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic [7:0]  adr       = 8'h00;
    logic [31:0] wdat      = 32'h0;
    logic [3:0]  sel       = 4'h0;
    logic        we        = 1'b0;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic [31:0] rdat;
    logic        ack;
    logic        line;
    logic        line_d    = 1'b0;
    logic        ring_valid;
    logic        irq;
    logic        run       = 1'b0;
    logic [15:0] gap       = 16'd150;
    logic [7:0]  rd;
    int          cyc_n     = 0;
    int          last_ev   = 0;
    int          failures  = 0;
    int          cmp_count = 0;

    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    ring_signal_validation #(.TICK_LEN(TL)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
        .wb_ack_o(ack), .line_polarity_i(line), .ring_valid_o(ring_valid), .irq_o(irq));
    ring_line_model line_m (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .run_i(run), .gap_i(gap),
        .line_polarity_o(line));

    always @(posedge sys_clk_i) begin
        cyc_n  <= cyc_n + 1;
        line_d <= line;
        if (line !== line_d) begin
            last_ev <= cyc_n;
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic wb_acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h000000, d};
        sel  <= 4'hF;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        rd = rdat[7:0];
        if (n >= 100) begin
            failures++;
            $display("BAD %0t no ack", $time);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb_acc

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi, input string m);
        cmp_count++;
        if (got < lo || got > hi) begin
            failures++;
            $display("BAD %0t %s took %0d not in %0d..%0d", $time, m, got, lo, hi);
        end
    endtask : chk_rng

    task automatic wait_valid(input logic lvl, input int lim);
        int n;
        n = 0;
        while (ring_valid !== lvl && n < lim) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask : wait_valid

    // Assertion time 20 ticks, threshold 10: a 15 tick gap lands inside the window
    task automatic setup(input logic [2:0] c, input logic [2:0] d, input logic [3:0] t, input logic en);
        wb_acc(1'b1, OFS_DELAY_MAX, {d[1:0], 6'd10});
        wb_acc(1'b1, OFS_TIMING, {d[2], t, c});
        wb_acc(1'b1, OFS_ENABLE, {en, 1'b0, 6'd20});
        wb_acc(1'b0, OFS_EVENT, 8'h00);
    endtask : setup

    task automatic run_ring(input logic [2:0] c, input logic [2:0] d, input logic [3:0] t);
        int t0;
        int ex;
        setup(c, d, t, 1'b1);
        wb_acc(1'b1, OFS_MASK, 8'h03);
        gap <= 16'd150;
        run <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        t0 = last_ev;
        ex = (CONFIRM_MS[c] + DELAY_MS[d[1:0]]) / TICK_MS * TL;
        wait_valid(1'b1, ex + 200);
        chk_rng(cyc_n - t0, ex - 20, ex + 40, "valid rise");
        wb_acc(1'b0, OFS_STATE, 8'h00);
        chk(rd, 8'h0F, "state valid");
        run <= 1'b0;
        ex = 32'(t) * TMO_STEP_MS / TICK_MS * TL;
        wait_valid(1'b0, ex + 200);
        chk_rng(cyc_n - last_ev, ex - 20, ex + 40, "valid drop");
        chk(irq, 1'b1, "irq set");
        wb_acc(1'b0, OFS_EVENT, 8'h00);
        chk(rd, 8'h03, "events");
        repeat (2) @(posedge sys_clk_i);
        chk(irq, 1'b0, "irq clear");
    endtask : run_ring

    task automatic bad_ring(input logic [15:0] g, input string m);
        setup(3'd0, 3'd0, 4'd1, 1'b1);
        wb_acc(1'b1, OFS_MASK, 8'h00);
        gap <= g;
        run <= 1'b1;
        repeat (1200) @(posedge sys_clk_i);
        chk(ring_valid, 1'b0, m);
        chk(irq, 1'b0, "irq masked");
        wb_acc(1'b1, OFS_MASK, 8'h04);
        repeat (3) @(posedge sys_clk_i);
        chk(irq, 1'b1, "irq unmasked");
        run <= 1'b0;
        repeat (900) @(posedge sys_clk_i);
        wb_acc(1'b0, OFS_EVENT, 8'h00);
        chk(rd, 8'h04, m);
        $display("test %s done", m);
    endtask : bad_ring

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        #360000;
        failures++;
        $display("BAD %0t watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        logic [2:0] dl[4];
        dl = '{3'd0, 3'd1, 3'd2, 3'd7};
        repeat (20) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        wb_acc(1'b0, OFS_ENABLE, 8'h00);
        chk(rd, 8'h19, "enable reset");
        wb_acc(1'b0, OFS_TIMING, 8'h00);
        chk(rd, RST_TIMING, "timing reset");
        wb_acc(1'b0, OFS_DELAY_MAX, 8'h00);
        chk(rd, RST_DELAY_MAX, "delay reset");
        wb_acc(1'b0, OFS_MASK, 8'h00);
        chk(rd, 8'h00, "mask reset");
        wb_acc(1'b0, 8'h30, 8'h00);
        chk(rd, 8'h00, "unmapped");
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            run_ring(3'(c), 3'd0, 4'd1);
        end
        $display("test confirm times done");
        foreach (dl[i]) begin
            run_ring(3'd0, dl[i], 4'd1);
        end
        $display("test report delays done");
        run_ring(3'd0, 3'd0, 4'd15);
        $display("test long timeout done");
        bad_ring(16'd30, "too fast");
        bad_ring(16'd250, "too slow");
        setup(3'd0, 3'd0, 4'd1, 1'b0);
        gap <= 16'd150;
        run <= 1'b1;
        repeat (1500) @(posedge sys_clk_i);
        run <= 1'b0;
        chk(ring_valid, 1'b0, "disabled valid");
        wb_acc(1'b0, OFS_EVENT, 8'h00);
        chk(rd, 8'h00, "disabled events");
        $display("test disabled done");
        tally_and_finish();
    end
endmodule : tb
